// ---- rtl/bmcr_defs.svh ----
`ifndef BMCR_DEFS_SVH
`define BMCR_DEFS_SVH

// Register indices on the register port
`define BMCR_IDX_MISC        2'h0
`define BMCR_IDX_MISC2       2'h1
`define BMCR_IDX_ARB         2'h2

// Reset values and writable masks
`define BMCR_MISC_RST        32'h0000_0000
`define BMCR_MISC2_RST       32'h0000_0000
`define BMCR_ARB_RST         32'h0000_0000
`define BMCR_MISC_WMASK      32'h0000_3f1c
`define BMCR_MISC2_WMASK     32'h003f_1ffe
`define BMCR_ARB_WMASK       32'h0000_075f

// Field positions of misc_control
`define BMCR_F_MODE_HI       1
`define BMCR_F_MODE_LO       0
`define BMCR_F_BYTE_ORDER    2
`define BMCR_F_SOFT_RST      3
`define BMCR_F_MA_RESP       4
`define BMCR_F_PFC_HI        13
`define BMCR_F_PFC_LO        8

// Field positions of misc_control_two
`define BMCR_F_TGT_DIS       0
`define BMCR_F_PER_IMAGE     1
`define BMCR_F_HOLD_BUS      2
`define BMCR_F_RETRY_HI      5
`define BMCR_F_RETRY_LO      4
`define BMCR_F_STALL_EN      6
`define BMCR_F_TA_ERR_EN     7
`define BMCR_F_BURST_EN      8
`define BMCR_F_SINGLE        9
`define BMCR_F_DUAL_ACC      10
`define BMCR_F_NO_ORDER      11
`define BMCR_F_PW_BOOST      12
`define BMCR_F_PFC1_HI       21
`define BMCR_F_PFC1_LO       16

// Field positions of pci_arbiter_control
`define BMCR_F_EXT_PRI_HI    3
`define BMCR_F_EXT_PRI_LO    0
`define BMCR_F_OWN_PRI       4
`define BMCR_F_ARB_EN        5
`define BMCR_F_PARK_EN       6
`define BMCR_F_PARK_HI       10
`define BMCR_F_PARK_LO       8

// Arbiter size and timing counts
`define BMCR_NUM_MASTERS     5
`define BMCR_OWN_MASTER      3'h4
`define BMCR_STALL_CLKS      4'h8
`define BMCR_STALL_MAX       4'hf

`endif

// ---- rtl/bmcr_pkg.sv ----
package bmcr_pkg;

  typedef enum logic [1:0] {
    mode_basic,
    mode_alt,
    mode_burst,
    mode_spare
  } bmcr_mode_t;

  typedef struct packed {
    logic [1:0]  mode_s1;
    logic [1:0]  mode_s2;
    logic        arb_s1;
    logic        arb_s2;
    logic        dis_s1;
    logic        dis_s2;
    logic        capture_pending;
    logic [31:0] misc;
    logic [31:0] misc2;
    logic [31:0] arb;
    logic        ack;
    logic [31:0] rdata;
    logic [7:0]  retry_cnt;
    logic [3:0]  stall_cnt;
    logic        disc;
    logic        bus_err;
    logic        ma_normal;
    logic [5:0]  pf_cnt;
    logic [1:0]  big_endian;
    logic [1:0]  burst_ok;
  } bmcr_regs_t;

  typedef struct packed {
    logic [4:0] grant;
    logic [2:0] ptr;
  } bmcr_arb_t;

endpackage

// ---- rtl/bmcr_arbiter.sv ----
`include "bmcr_defs.svh"

module bmcr_arbiter (
  input  wire logic       mclk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       enable_in,
  input  wire logic [4:0] req_in,
  input  wire logic [3:0] ext_prio_in,
  input  wire logic       own_prio_in,
  input  wire logic       park_en_in,
  input  wire logic [2:0] park_sel_in,
  output logic      [4:0] grant_out
);

  bmcr_pkg::bmcr_arb_t st;
  bmcr_pkg::bmcr_arb_t next_st;

  // Rotating search for the first candidate from start
  function automatic logic [2:0] bmcr_pick(input logic [4:0] cand, input logic [2:0] start);
    logic [2:0] idx;
    logic [2:0] found;
    logic       hit;
    found = 3'h0;
    hit   = 1'b0;
    idx   = start;
    for (int i = 0; i < `BMCR_NUM_MASTERS; i++)
    begin
      if (!hit && cand[idx])
      begin
        found = idx;
        hit   = 1'b1;
      end
      idx = (idx == `BMCR_OWN_MASTER) ? 3'h0 : 3'(idx + 3'h1);
    end
    return found;
  endfunction

  logic [4:0] high_req;
  logic [4:0] cand;
  logic [2:0] win;

  always_comb
  begin
    next_st  = st;
    high_req = req_in & {own_prio_in, ext_prio_in};
    cand     = (|high_req) ? high_req : req_in;
    win      = bmcr_pick(cand, st.ptr);
    if (!enable_in)
    begin
      next_st.grant = 5'h00;
    end
    else if (|(st.grant & req_in))
    begin
      next_st.grant = st.grant;
    end
    else if (|cand)
    begin
      next_st.grant = 5'(5'h01 << win);
      next_st.ptr   = (win == `BMCR_OWN_MASTER) ? 3'h0 : 3'(win + 3'h1);
    end
    else if (park_en_in)
    begin
      if (park_sel_in > `BMCR_OWN_MASTER)
        next_st.grant = 5'(5'h01 << `BMCR_OWN_MASTER);
      else
        next_st.grant = 5'(5'h01 << park_sel_in);
    end
    else
    begin
      next_st.grant = 5'h00;
    end
    if (sys_rst_in)
    begin
      next_st = '0;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    st <= next_st;
  end

  assign grant_out = st.grant;

endmodule

// ---- rtl/bmcr_top.sv ----
`include "bmcr_defs.svh"

module bmcr_top (
  input  wire logic        mclk_in,
  input  wire logic        sys_rst_in,
  input  wire logic [1:0]  mode_strap_in,
  input  wire logic        arb_en_strap_in,
  input  wire logic        tgt_dis_strap_in,
  input  wire logic        reg_cs_in,
  input  wire logic        reg_we_in,
  input  wire logic [1:0]  reg_idx_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic [1:0]  invert_byte_order_in,
  input  wire logic [1:0]  image_burst_write_en_in,
  input  wire logic        tgt_image_in,
  input  wire logic        pci_master_abort_in,
  input  wire logic        pci_target_abort_in,
  input  wire logic        pci_retry_in,
  input  wire logic        pci_cycle_done_in,
  input  wire logic        pci_tgt_active_in,
  input  wire logic        pci_trdy_n_in,
  input  wire logic [4:0]  pci_req_in,
  output logic      [31:0] reg_rdata_out,
  output logic             reg_ack_out,
  output logic      [1:0]  bus_mode_select_out,
  output logic      [1:0]  big_endian_out,
  output logic             reset_output_pin_n_out,
  output logic             local_bus_error_out,
  output logic             ma_normal_term_out,
  output logic      [5:0]  prefetch_count_out,
  output logic             target_retry_out,
  output logic             hold_local_bus_out,
  output logic             target_disconnect_out,
  output logic      [1:0]  burst_permit_out,
  output logic             single_access_only_out,
  output logic             ordering_disable_out,
  output logic             posted_write_boost_out,
  output logic             dual_side_reg_access_out,
  output logic      [4:0]  pci_grant_out
);

  bmcr_pkg::bmcr_regs_t st;
  bmcr_pkg::bmcr_regs_t next_st;

  // Masked register update
  function automatic logic [31:0] bmcr_merge(input logic [31:0] old_val,
                                             input logic [31:0] new_val,
                                             input logic [31:0] wmask);
    return (new_val & wmask) | (old_val & ~wmask);
  endfunction

  logic       wr_en;
  logic [1:0] retry_limit;
  logic [7:0] retry_threshold;
  logic [7:0] retry_next;
  logic       retry_fail;
  logic       burst_mode;
  logic       single_only;

  always_comb
  begin
    next_st         = st;
    wr_en           = reg_cs_in & reg_we_in;
    retry_limit     = st.misc2[`BMCR_F_RETRY_HI:`BMCR_F_RETRY_LO];
    retry_threshold = {retry_limit, 6'h00};
    retry_next      = 8'h00;
    retry_fail      = 1'b0;
    burst_mode      = (bmcr_pkg::bmcr_mode_t'(st.misc[`BMCR_F_MODE_HI:`BMCR_F_MODE_LO])
                       == bmcr_pkg::mode_burst);
    single_only     = st.misc2[`BMCR_F_SINGLE] & burst_mode;
    if (sys_rst_in)
    begin
      next_st                 = '0;
      next_st.misc            = `BMCR_MISC_RST;
      next_st.misc2           = `BMCR_MISC2_RST;
      next_st.arb             = `BMCR_ARB_RST;
      next_st.capture_pending = 1'b1;
    end
    else
    begin
      // Register port
      next_st.ack = reg_cs_in;
      case (reg_idx_in)
        `BMCR_IDX_MISC:  next_st.rdata = st.misc;
        `BMCR_IDX_MISC2: next_st.rdata = st.misc2;
        `BMCR_IDX_ARB:   next_st.rdata = st.arb;
        default:         next_st.rdata = 32'h0000_0000;
      endcase
      if (wr_en)
      begin
        case (reg_idx_in)
          `BMCR_IDX_MISC:
          begin
            next_st.misc = bmcr_merge(st.misc, reg_wdata_in, `BMCR_MISC_WMASK);
          end
          `BMCR_IDX_MISC2:
          begin
            next_st.misc2 = bmcr_merge(st.misc2, reg_wdata_in, `BMCR_MISC2_WMASK);
            if (!reg_wdata_in[`BMCR_F_TGT_DIS])
              next_st.misc2[`BMCR_F_TGT_DIS] = 1'b0;
          end
          `BMCR_IDX_ARB:
          begin
            next_st.arb = bmcr_merge(st.arb, reg_wdata_in, `BMCR_ARB_WMASK);
          end
          default:
          begin
            next_st.rdata = 32'h0000_0000;
          end
        endcase
      end
      // Straps caught once, just after reset release
      if (st.capture_pending)
      begin
        next_st.capture_pending                       = 1'b0;
        next_st.misc[`BMCR_F_MODE_HI:`BMCR_F_MODE_LO] = st.mode_s2;
        next_st.arb[`BMCR_F_ARB_EN]                   = st.arb_s2;
        if (st.dis_s2)
          next_st.misc2[`BMCR_F_TGT_DIS] = 1'b1;
      end
      // Retry accounting of the current local slave cycle
      retry_next = (st.retry_cnt == 8'hff) ? st.retry_cnt : 8'(st.retry_cnt + 8'h01);
      if (pci_cycle_done_in)
      begin
        next_st.retry_cnt = 8'h00;
      end
      else if (pci_retry_in)
      begin
        if ((retry_limit != 2'h0) && (retry_next >= retry_threshold))
        begin
          retry_fail        = 1'b1;
          next_st.retry_cnt = 8'h00;
        end
        else
        begin
          next_st.retry_cnt = retry_next;
        end
      end
      // Errors towards the local processor
      next_st.bus_err = (pci_master_abort_in & st.misc[`BMCR_F_MA_RESP])
                      | (pci_target_abort_in & st.misc2[`BMCR_F_TA_ERR_EN])
                      | retry_fail;
      next_st.ma_normal = pci_master_abort_in & ~st.misc[`BMCR_F_MA_RESP];
      // Target ready stall watch
      if (pci_tgt_active_in && pci_trdy_n_in)
      begin
        if (st.stall_cnt != `BMCR_STALL_MAX)
          next_st.stall_cnt = 4'(st.stall_cnt + 4'h1);
      end
      else
      begin
        next_st.stall_cnt = 4'h0;
      end
      next_st.disc = st.misc2[`BMCR_F_STALL_EN] & pci_tgt_active_in & pci_trdy_n_in
                   & (next_st.stall_cnt > `BMCR_STALL_CLKS);
      // Prefetch count for the addressed target image
      if (st.misc2[`BMCR_F_PER_IMAGE] && tgt_image_in)
        next_st.pf_cnt = st.misc2[`BMCR_F_PFC1_HI:`BMCR_F_PFC1_LO];
      else
        next_st.pf_cnt = st.misc[`BMCR_F_PFC_HI:`BMCR_F_PFC_LO];
      // Byte order per image
      next_st.big_endian = {2{st.misc[`BMCR_F_BYTE_ORDER]}} ^ invert_byte_order_in;
      // Burst permission per image
      next_st.burst_ok = {2{st.misc2[`BMCR_F_BURST_EN] & burst_mode & ~single_only}}
                       & image_burst_write_en_in;
    end
    // Strap synchronisers run through reset
    next_st.mode_s1 = mode_strap_in;
    next_st.mode_s2 = st.mode_s1;
    next_st.arb_s1  = arb_en_strap_in;
    next_st.arb_s2  = st.arb_s1;
    next_st.dis_s1  = tgt_dis_strap_in;
    next_st.dis_s2  = st.dis_s1;
  end

  always_ff @(posedge mclk_in)
  begin
    st <= next_st;
  end

  bmcr_arbiter u_arbiter (
    .mclk_in     (mclk_in),
    .sys_rst_in  (sys_rst_in),
    .enable_in   (st.arb[`BMCR_F_ARB_EN]),
    .req_in      (pci_req_in),
    .ext_prio_in (st.arb[`BMCR_F_EXT_PRI_HI:`BMCR_F_EXT_PRI_LO]),
    .own_prio_in (st.arb[`BMCR_F_OWN_PRI]),
    .park_en_in  (st.arb[`BMCR_F_PARK_EN]),
    .park_sel_in (st.arb[`BMCR_F_PARK_HI:`BMCR_F_PARK_LO]),
    .grant_out   (pci_grant_out)
  );

  assign reg_rdata_out            = st.rdata;
  assign reg_ack_out              = st.ack;
  assign bus_mode_select_out      = st.misc[`BMCR_F_MODE_HI:`BMCR_F_MODE_LO];
  assign big_endian_out           = st.big_endian;
  assign reset_output_pin_n_out   = ~st.misc[`BMCR_F_SOFT_RST];
  assign local_bus_error_out      = st.bus_err;
  assign ma_normal_term_out       = st.ma_normal;
  assign prefetch_count_out       = st.pf_cnt;
  assign target_retry_out         = st.misc2[`BMCR_F_TGT_DIS];
  assign hold_local_bus_out       = st.misc2[`BMCR_F_HOLD_BUS];
  assign target_disconnect_out    = st.disc;
  assign burst_permit_out         = st.burst_ok;
  assign single_access_only_out   = single_only;
  assign ordering_disable_out     = st.misc2[`BMCR_F_NO_ORDER];
  assign posted_write_boost_out   = st.misc2[`BMCR_F_PW_BOOST];
  assign dual_side_reg_access_out = st.misc2[`BMCR_F_DUAL_ACC];

endmodule

// ---- verif/bmcr_pci_model.sv ----
module bmcr_pci_model (
  input  wire logic       mclk_in,
  input  wire logic       sys_rst_in,
  input  wire logic [4:0] start_in,
  input  wire logic       act_in,
  input  wire logic       stall_in,
  input  wire logic [4:0] grant_in,
  output logic      [4:0] req_out,
  output logic            active_out,
  output logic            trdy_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Each master drops its request once it sees its grant
  always_ff @(posedge mclk_in)
  begin
    req_out <= sys_rst_in ? 5'h00 : (req_out & ~grant_in) | start_in;
  end
  // Ready is pulled up outside a target phase
  assign active_out = act_in;
  assign trdy_n_out = !act_in || stall_in;
endmodule

// ---- verif/bmcr_top_properties.sv ----
module bmcr_checker (
  input wire logic        mclk_in,
  input wire logic        sys_rst_in,
  input wire logic        arb_en_strap_in,
  input wire logic        reg_cs_in,
  input wire logic        reg_we_in,
  input wire logic [1:0]  reg_idx_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic        pci_master_abort_in,
  input wire logic        pci_target_abort_in,
  input wire logic        pci_retry_in,
  input wire logic        pci_tgt_active_in,
  input wire logic        pci_trdy_n_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic        reg_ack_out,
  input wire logic [1:0]  bus_mode_select_out,
  input wire logic        reset_output_pin_n_out,
  input wire logic        local_bus_error_out,
  input wire logic        ma_normal_term_out,
  input wire logic        target_disconnect_out,
  input wire logic [4:0]  pci_grant_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] stall_run;
  logic       arb_off;
  // Stalled cycles in a row, and the arbiter strap seen during reset
  always_ff @(posedge mclk_in)
  begin
    arb_off <= sys_rst_in ? !arb_en_strap_in : arb_off;
    if (sys_rst_in || !(pci_tgt_active_in && pci_trdy_n_in))
      stall_run <= 4'h0;
    else if (stall_run != 4'hf)
      stall_run <= stall_run + 4'h1;
  end
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (sys_rst_in);
  ack_follows_cs_a: assert property (reg_ack_out == $past(reg_cs_in))
    else $error("ack does not follow request");
  unmapped_reads_zero_a: assert property (reg_cs_in && !reg_we_in && reg_idx_in == 2'h3 |=>
    reg_rdata_out == 32'h0) else $error("unmapped read not zero");
  mode_held_a: assert property (!$past(sys_rst_in) && !$past(sys_rst_in, 2) |->
    $stable(bus_mode_select_out)) else $error("mode changed after power-up");
  soft_reset_pin_a: assert property (reg_cs_in && reg_we_in && reg_idx_in == 2'h0 |->
    ##2 reset_output_pin_n_out == !$past(reg_wdata_in[3], 2)) else $error("reset pin wrong");
  error_has_cause_a: assert property (local_bus_error_out |->
    $past(pci_master_abort_in || pci_target_abort_in || pci_retry_in)) else $error("stray error");
  normal_term_cause_a: assert property (ma_normal_term_out |-> $past(pci_master_abort_in))
    else $error("stray normal termination");
  stall_disconnect_a: assert property (target_disconnect_out |-> stall_run >= 4'h9)
    else $error("disconnect too early");
  arbiter_off_a: assert property (arb_off |-> pci_grant_out == 5'h00)
    else $error("grant with arbiter disabled");
endmodule

// ---- verif/tb_bmcr_top.sv ----
`include "bmcr_defs.svh"

module tb_bmcr_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_in, sys_rst_in, arb_en_strap_in, tgt_dis_strap_in, reg_cs_in, reg_we_in;
  logic        tgt_image_in, pci_master_abort_in, pci_target_abort_in, pci_retry_in;
  logic        pci_cycle_done_in, pci_tgt_active_in, pci_trdy_n_in, reg_ack_out, tgt_act;
  logic        reset_output_pin_n_out, local_bus_error_out, ma_normal_term_out, tgt_stall;
  logic        target_retry_out, hold_local_bus_out, target_disconnect_out;
  logic        single_access_only_out, ordering_disable_out, posted_write_boost_out;
  logic        dual_side_reg_access_out;
  logic [1:0]  mode_strap_in, reg_idx_in, invert_byte_order_in, image_burst_write_en_in;
  logic [1:0]  bus_mode_select_out, big_endian_out, burst_permit_out;
  logic [4:0]  pci_req_in, pci_grant_out, want;
  logic [5:0]  prefetch_count_out;
  logic [31:0] reg_wdata_in, reg_rdata_out, v, vals[3];
  logic [32:0] note, notes[$];
  int          mismatches, tests_run, cycles;
  localparam logic [31:0] wmask[3] = '{`BMCR_MISC_WMASK, `BMCR_MISC2_WMASK, `BMCR_ARB_WMASK};
  localparam logic [31:0] ro_bits[3] = '{32'h2, 32'h1, 32'h20};

  bmcr_top dut (.*);
  bmcr_pci_model pci (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .start_in(want),
    .act_in(tgt_act), .stall_in(tgt_stall), .grant_in(pci_grant_out), .req_out(pci_req_in),
    .active_out(pci_tgt_active_in), .trdy_n_out(pci_trdy_n_in));
  always #12.5 mclk_in = ~mclk_in;

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  // Write when w is set; a read notes v as the expected data
  task automatic acc(input logic w, input logic [1:0] i, input logic [31:0] v);
    @(posedge mclk_in);
    reg_cs_in <= 1'b1;
    reg_we_in <= w;
    reg_idx_in <= i;
    reg_wdata_in <= w ? v : 32'h0;
    notes.push_back({!w, v});
    @(posedge mclk_in);
    reg_cs_in <= 1'b0;
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(negedge mclk_in)
  begin
    cycles++;
    if (reg_ack_out === 1'b1)
    begin
      note = notes.pop_front();
      if (note[32])
        chk("read data", reg_rdata_out, note[31:0]);
    end
    if (cycles == 5000)
    begin
      mismatches++;
      summarize();
    end
  end

  initial
  begin
    mclk_in = 1'b0;
    {reg_cs_in, reg_we_in, reg_idx_in, reg_wdata_in, tgt_image_in, want, tgt_act} = '0;
    {tgt_stall, pci_master_abort_in, pci_target_abort_in, pci_retry_in} = '0;
    {pci_cycle_done_in, invert_byte_order_in, image_burst_write_en_in} = '0;
    {mode_strap_in, arb_en_strap_in, tgt_dis_strap_in, sys_rst_in} = 5'h17;
    void'($urandom(85875));
    repeat (16) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    for (int i = 0; i < 4; i++)
      acc(1'b0, i[1:0], i < 3 ? ro_bits[i] : 32'h0);
    cyc(2);
    chk("mode", bus_mode_select_out, 32'h2);
    chk("target retry", target_retry_out, 32'h1);
    $display("test straps finished");
    for (int i = 0; i < 3; i++)
    begin
      v = $urandom() | 32'h1;
      vals[i] = v;
      acc(1'b1, i[1:0], v);
      acc(1'b0, i[1:0], (v & wmask[i]) | ro_bits[i]);
    end
    acc(1'b1, 2'h3, 32'hffff_ffff);
    acc(1'b0, 2'h3, 32'h0);
    cyc(2);
    chk("reset pin", reset_output_pin_n_out, !vals[0][3]);
    chk("hold bus", hold_local_bus_out, vals[1][2]);
    chk("dual access", dual_side_reg_access_out, vals[1][10]);
    chk("ordering", ordering_disable_out, vals[1][11]);
    chk("write boost", posted_write_boost_out, vals[1][12]);
    chk("target retry", target_retry_out, 32'h1);
    acc(1'b1, 2'h1, 32'h0);
    cyc(2);
    chk("target retry", target_retry_out, 32'h0);
    $display("test registers finished");
    for (int b = 0; b < 2; b++)
    begin
      acc(1'b1, 2'h0, {29'h0, b[0], 2'h0});
      invert_byte_order_in <= 2'h1;
      cyc(3);
      chk("endian", big_endian_out, {30'h0, b[0], !b[0]});
    end
    for (int k = 0; k < 4; k++)
    begin
      acc(1'b1, 2'h0, {27'h0, k[0], 4'h0});
      acc(1'b1, 2'h1, {24'h0, k[1], 7'h0});
      @(posedge mclk_in);
      pci_master_abort_in <= 1'b1;
      @(posedge mclk_in);
      pci_master_abort_in <= 1'b0;
      #1;
      chk("abort error", local_bus_error_out, k[0]);
      chk("abort normal", ma_normal_term_out, !k[0]);
      @(posedge mclk_in);
      pci_target_abort_in <= 1'b1;
      @(posedge mclk_in);
      pci_target_abort_in <= 1'b0;
      #1;
      chk("target abort", local_bus_error_out, k[1]);
    end
    acc(1'b1, 2'h1, 32'h10);
    pci_cycle_done_in <= 1'b1;
    @(posedge mclk_in);
    pci_cycle_done_in <= 1'b0;
    pci_retry_in <= 1'b1;
    cyc(63);
    chk("retry early", local_bus_error_out, 32'h0);
    @(posedge mclk_in);
    pci_retry_in <= 1'b0;
    #1;
    chk("retry error", local_bus_error_out, 32'h1);
    $display("test events finished");
    for (int e = 0; e < 2; e++)
    begin
      acc(1'b1, 2'h1, {25'h0, e[0], 6'h0});
      tgt_act <= 1'b1;
      tgt_stall <= 1'b1;
      cyc(8);
      chk("disconnect", target_disconnect_out, 32'h0);
      cyc(1);
      chk("disconnect", target_disconnect_out, e);
      @(posedge mclk_in);
      tgt_stall <= 1'b0;
      tgt_act <= 1'b0;
      cyc(2);
      chk("disconnect end", target_disconnect_out, 32'h0);
    end
    acc(1'b1, 2'h0, 32'h0000_0500);
    for (int k = 0; k < 3; k++)
    begin
      acc(1'b1, 2'h1, {10'h0, 6'h09, 14'h0, k < 2, 1'b0});
      tgt_image_in <= (k != 1);
      cyc(3);
      chk("prefetch", prefetch_count_out, k == 0 ? 32'h9 : 32'h5);
    end
    acc(1'b1, 2'h1, 32'h100);
    image_burst_write_en_in <= 2'h2;
    cyc(3);
    chk("burst", burst_permit_out, 32'h2);
    acc(1'b1, 2'h1, 32'h300);
    cyc(3);
    chk("single", single_access_only_out, 32'h1);
    chk("burst off", burst_permit_out, 32'h0);
    $display("test datapath controls finished");
    for (int p = 0; p < 2; p++)
    begin
      acc(1'b1, 2'h2, p == 0 ? 32'h4 : 32'h10);
      want <= 5'h1f;
      @(posedge mclk_in);
      want <= 5'h00;
      // Wait one cycle, then up to 20 more for the first grant to appear
      cyc(1);
      for (int n = 0; n < 20 && pci_grant_out === 5'h00; n++)
        cyc(1);
      chk("first grant", pci_grant_out, p == 0 ? 32'h4 : 32'h10);
      cyc(30);
    end
    for (int s = 0; s < 8; s++)
    begin
      acc(1'b1, 2'h2, {21'h0, s[2:0], 8'h40});
      cyc(3);
      chk("park", pci_grant_out, s > 4 ? 32'h10 : 32'h1 << s);
    end
    $display("test arbiter finished");
    @(posedge mclk_in);
    {mode_strap_in, arb_en_strap_in, tgt_dis_strap_in, sys_rst_in} <= 5'h09;
    repeat (16) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    acc(1'b0, 2'h0, 32'h1);
    acc(1'b0, 2'h1, 32'h0);
    acc(1'b0, 2'h2, 32'h0);
    acc(1'b1, 2'h2, 32'h15f);
    want <= 5'h1f;
    cyc(10);
    chk("grant off", pci_grant_out, 32'h0);
    chk("mode", bus_mode_select_out, 32'h1);
    chk("target retry", target_retry_out, 32'h0);
    $display("test second reset finished");
    summarize();
  end
endmodule

bind bmcr_top bmcr_checker chk (.*);
